// [include/uvepc_pkg.sv]
// Package of constants and types for the EPROM host controller
package uvepc_pkg;
  // Device geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // Clock rate and timing figures
  localparam int CLK_MHZ         = 125;
  localparam int ACCESS_NS       = 150; // address_to_data_delay / select_to_data_delay
  localparam int OE_DELAY_NS     = 75;
  localparam int FLOAT_NS        = 50;
  localparam int SETUP_US        = 2;
  localparam int PULSE_US        = 1000;
  localparam int VERIFY_OE_NS    = 150;
  localparam int ACCESS_CYC      = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int OE_CYC          = (OE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int FLOAT_CYC       = (FLOAT_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC       = SETUP_US * CLK_MHZ;
  localparam int PULSE_CYC       = PULSE_US * CLK_MHZ;
  localparam int VERIFY_CYC      = (VERIFY_OE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W           = 24;
  // Signature address: identification line is bit 9, byte select bit 0
  localparam int ID_LINE_BIT     = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Commands
  typedef enum logic [1:0] {
    UVEPC_CMD_READ = 2'h0,
    UVEPC_CMD_PROG = 2'h1,
    UVEPC_CMD_SIG  = 2'h2
  } uvepc_cmd_t;
endpackage : uvepc_pkg

// [include/uvepc_tmr_if.sv]
// Interface between the sequencer and its wait timer
interface uvepc_tmr_if;
  import uvepc_pkg::*;
  logic             start;
  logic [CNT_W-1:0] load;
  logic             done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface : uvepc_tmr_if

// [rtl/uvepc_timer.sv]
// Down counter that marks the end of a programmed wait
module uvepc_timer
  import uvepc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Timer link
  uvepc_tmr_if.tmr tmr
);
  import uvepc_pkg::*;
  logic [CNT_W-1:0] count_ff;
  logic             busy_ff;

  // Load on start, count to one, then flag done for one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
      busy_ff  <= 1'b0;
    end else if (tmr.start) begin
      count_ff <= tmr.load;
      busy_ff  <= 1'b1;
    end else if (busy_ff) begin
      count_ff <= count_ff - CNT_W'(1);
      if (count_ff <= CNT_W'(1)) busy_ff <= 1'b0;
    end
  end

  // Not gated by start: the sequencer derives start from done, a gate would close a loop
  assign tmr.done = busy_ff && (count_ff <= CNT_W'(1));
endmodule : uvepc_timer

// [rtl/uvepc_host.sv]
// Host controller that reads, programs and identifies a UV EPROM through its pins
// How it works
// - The byte to write is driven on the eight data pins during programming.
// - A write is one low select pulse with the programming supply raised.
// - Signature mode raises the identification address line to high voltage.
// - Two identification bytes are read, byte select low then high.
// - All other address lines are held low in signature mode.
// - Select decodes the device; the gate follows the read strobe.
// - One shared select pulse programs all tied devices alike.
module uvepc_host
  import uvepc_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // Command port
  input  wire logic                      cmdValid,
  output logic                           cmdReady,
  input  wire uvepc_pkg::uvepc_cmd_t     cmdOp,
  input  wire logic [uvepc_pkg::ADDR_W-1:0] cmdAddr,
  input  wire logic [uvepc_pkg::DATA_W-1:0] cmdData,
  output logic                           rspValid,
  output logic [uvepc_pkg::DATA_W-1:0]   rspData,
  output logic [uvepc_pkg::DATA_W-1:0]   rspType,
  output logic                           rspErased,
  output logic                           rspMismatch,
  // Device pins
  output logic [uvepc_pkg::ADDR_W-1:0]   memAddr,
  output logic                           chipSel_n,
  output logic                           outGate_n,
  output logic                           progSupplyHigh,
  output logic                           idHighVoltageLine,
  input  wire logic [uvepc_pkg::DATA_W-1:0] memDataIn,
  output logic [uvepc_pkg::DATA_W-1:0]   memDataOut,
  output logic                           memDataOe
);
  import uvepc_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_RDSET = 9'h002,
    S_RDOE  = 9'h004,
    S_FLOAT = 9'h008,
    S_PSET  = 9'h010,
    S_PULSE = 9'h020,
    S_PHOLD = 9'h040,
    S_VER   = 9'h080,
    S_SIG2  = 9'h100
  } uvepc_state_t;

  uvepc_state_t     state_ff, nxt_state;
  uvepc_cmd_t       op_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic             sigHi_ff;
  uvepc_tmr_if      tmrBus ();

  uvepc_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tmr     (tmrBus.tmr)
  );

  assign cmdReady = (state_ff == S_IDLE);

  // Sequencer state and timer kicks
  always_comb begin
    nxt_state     = state_ff;
    tmrBus.start  = 1'b0;
    tmrBus.load   = CNT_W'(ACCESS_CYC);
    case (state_ff)
      S_IDLE: if (cmdValid) begin
        tmrBus.start = 1'b1;
        if (cmdOp == UVEPC_CMD_PROG) begin
          nxt_state   = S_PSET;
          tmrBus.load = CNT_W'(SETUP_CYC);
        end else begin
          nxt_state   = S_RDSET;
          tmrBus.load = CNT_W'(ACCESS_CYC);
        end
      end
      S_RDSET: if (tmrBus.done) begin
        nxt_state = S_RDOE;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(OE_CYC);
      end
      S_RDOE: if (tmrBus.done) begin
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(FLOAT_CYC);
        if (op_ff == UVEPC_CMD_SIG && !sigHi_ff) begin
          nxt_state = S_SIG2;
          tmrBus.load = CNT_W'(ACCESS_CYC);
        end else begin
          nxt_state = S_FLOAT;
        end
      end
      S_SIG2: if (tmrBus.done) begin
        nxt_state = S_RDOE;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(OE_CYC);
      end
      S_PSET: if (tmrBus.done) begin
        nxt_state = S_PULSE;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(PULSE_CYCLES);
      end
      S_PULSE: if (tmrBus.done) begin
        nxt_state = S_PHOLD;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(SETUP_CYC);
      end
      S_PHOLD: if (tmrBus.done) begin
        nxt_state = S_VER;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(VERIFY_CYC);
      end
      S_VER: if (tmrBus.done) begin
        nxt_state = S_FLOAT;
        tmrBus.start = 1'b1;
        tmrBus.load = CNT_W'(FLOAT_CYC);
      end
      S_FLOAT: if (tmrBus.done) nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) state_ff <= S_IDLE;
    else state_ff <= nxt_state;
  end

  // Command capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_ff    <= UVEPC_CMD_READ;
      wdata_ff <= ERASED_BYTE;
      memAddr  <= '0;
    end else if (state_ff == S_IDLE && cmdValid) begin
      op_ff    <= cmdOp;
      wdata_ff <= cmdData;
      // Signature needs every other line low, byte select low first
      memAddr  <= (cmdOp == UVEPC_CMD_SIG) ? '0 : cmdAddr;
    end else if (state_ff == S_RDOE && tmrBus.done && op_ff == UVEPC_CMD_SIG && !sigHi_ff) begin
      memAddr[0] <= 1'b1;
    end
  end

  // Pin levels per state; idle keeps select high so the part stays in standby
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chipSel_n         <= 1'b1;
      outGate_n         <= 1'b1;
      progSupplyHigh    <= 1'b0;
      idHighVoltageLine <= 1'b0;
      memDataOut        <= '0;
      memDataOe         <= 1'b0;
    end else begin
      chipSel_n <= !(nxt_state inside {S_RDSET, S_RDOE, S_SIG2, S_PULSE});
      outGate_n <= !(nxt_state inside {S_RDOE, S_VER});
      progSupplyHigh <= (nxt_state inside {S_PSET, S_PULSE, S_PHOLD, S_VER});
      // In idle only the new opcode counts; a stale signature opcode must not leak into a read
      idHighVoltageLine <= ((state_ff == S_IDLE) ? (cmdOp == UVEPC_CMD_SIG)
                                                 : (op_ff == UVEPC_CMD_SIG))
                           && (nxt_state inside {S_RDSET, S_RDOE, S_SIG2});
      // Drive only while the part takes data, never when its outputs may be on
      memDataOe  <= (nxt_state inside {S_PSET, S_PULSE, S_PHOLD});
      memDataOut <= (state_ff == S_IDLE) ? cmdData : wdata_ff;
    end
  end

  // Sampling and responses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rspValid    <= 1'b0;
      rspData     <= '0;
      rspType     <= '0;
      rspErased   <= 1'b0;
      rspMismatch <= 1'b0;
      sigHi_ff    <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      if (state_ff == S_IDLE) sigHi_ff <= 1'b0;
      if (state_ff == S_RDOE && tmrBus.done) begin
        if (op_ff == UVEPC_CMD_SIG && sigHi_ff) rspType <= memDataIn;
        else rspData <= memDataIn;
        if (op_ff == UVEPC_CMD_SIG) sigHi_ff <= 1'b1;
        if (op_ff != UVEPC_CMD_SIG || sigHi_ff) begin
          rspValid    <= 1'b1;
          rspErased   <= (memDataIn == ERASED_BYTE);
          rspMismatch <= 1'b0;
        end
      end
      if (state_ff == S_VER && tmrBus.done) begin
        rspValid    <= 1'b1;
        rspData     <= memDataIn;
        rspErased   <= (memDataIn == ERASED_BYTE);
        rspMismatch <= (memDataIn != wdata_ff);
      end
    end
  end

  // Assertions
  no_contend_a: assert property (@(posedge clk_sys) disable iff (rst)
    memDataOe |-> outGate_n) else $error("host drives while gate low");
  prog_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!chipSel_n && progSupplyHigh) |-> memDataOe) else $error("pulse without data");
  verify_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    (progSupplyHigh && !outGate_n) |-> chipSel_n) else $error("verify with select low");
  sig_lines_a: assert property (@(posedge clk_sys) disable iff (rst)
    idHighVoltageLine |-> (memAddr[ADDR_W-1:1] == '0)) else $error("address not low");
  sig_supply_a: assert property (@(posedge clk_sys) disable iff (rst)
    idHighVoltageLine |-> !progSupplyHigh) else $error("supply raised in signature");
  idle_standby_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdReady |-> chipSel_n && outGate_n) else $error("idle not standby");
  gate_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(outGate_n) && !progSupplyHigh |-> !chipSel_n [*3]) else $error("select lifted early");
  float_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!chipSel_n && outGate_n && !progSupplyHigh) |-> !memDataOe) else $error("drove in disable");
endmodule : uvepc_host

// [verification/uvepc_eprom_model.sv]
// Behavioural model of the UV EPROM seen from its pins
module uvepc_eprom_model
  import uvepc_pkg::*;
#(
  parameter int         OUT_DELAY_NS = 60,
  parameter logic [7:0] MAKER_CODE   = 8'h5a, // Arbitrary value
  parameter logic [7:0] TYPE_CODE    = 8'hc3  // Arbitrary value
) (
  // Control and address pins
  input  wire logic [uvepc_pkg::ADDR_W-1:0] memAddr,
  input  wire logic                         chipSel_n,
  input  wire logic                         outGate_n,
  input  wire logic                         progSupplyHigh,
  input  wire logic                         idHighVoltageLine,
  // Data bus
  input  wire logic [uvepc_pkg::DATA_W-1:0] busLevel,
  output logic      [uvepc_pkg::DATA_W-1:0] devData,
  output logic                              devDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] memArr [0:2**ADDR_W-1];
  logic [7:0] stale;
  logic [7:0] value;
  logic       sigMode;

  // Every cell starts erased
  initial begin
    stale = 8'h00;
    for (int i = 0; i < 2**ADDR_W; i++) memArr[i] = ERASED_BYTE;
  end

  // Read needs select and gate low; verify needs select high with supply up
  assign devDrive = !outGate_n && (chipSel_n == progSupplyHigh);
  assign sigMode = idHighVoltageLine && !progSupplyHigh;
  // Stray address bits in signature mode give garbage, not the codes
  assign value = !sigMode ? memArr[memAddr] :
                 ((memAddr & 15'h7dfe) != 15'h0000) ? 8'h00 :
                 memAddr[0] ? TYPE_CODE : MAKER_CODE;

  // Released bus shows the inverse, since there is no pull resistor
  assign #(OUT_DELAY_NS) devData = devDrive ? value : ~stale;
  always @(devData) begin
    if (devDrive) stale = devData;
  end

  // End of a select pulse with supply up clears only the zero bits
  always @(posedge chipSel_n) begin
    if (progSupplyHigh) memArr[memAddr] = memArr[memAddr] & busLevel;
  end
endmodule : uvepc_eprom_model

// [verification/tb_uv_eprom_mode_control.sv]
// Self-checking bench for the EPROM host controller
module tb_uv_eprom_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import uvepc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] TYPE  = 8'hc3; // Arbitrary value
  logic clk_sys, rst, cmdValid, cmdReady, rspValid, rspErased, rspMismatch;
  logic chipSel_n, outGate_n, progSupplyHigh, idHighVoltageLine, memDataOe, devDrive;
  uvepc_cmd_t  cmdOp;
  logic [14:0] cmdAddr, memAddr;
  logic [7:0]  cmdData, rspData, rspType, memDataOut, devData, busLevel, progByte;
  int          miscompares = 0;
  int          checksDone = 0;

  uvepc_host #(.PULSE_CYCLES(20)) DUT (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData), .rspType(rspType), .rspErased(rspErased),
    .rspMismatch(rspMismatch), .memAddr(memAddr), .chipSel_n(chipSel_n),
    .outGate_n(outGate_n), .progSupplyHigh(progSupplyHigh),
    .idHighVoltageLine(idHighVoltageLine), .memDataIn(busLevel),
    .memDataOut(memDataOut), .memDataOe(memDataOe));
  uvepc_eprom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(TYPE)) eprom (.memAddr(memAddr),
    .chipSel_n(chipSel_n), .outGate_n(outGate_n), .progSupplyHigh(progSupplyHigh),
    .idHighVoltageLine(idHighVoltageLine), .busLevel(busLevel), .devData(devData),
    .devDrive(devDrive));
  // Wire level from both drivers
  assign busLevel = memDataOe ? memDataOut : devData;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Holds the request until the taking edge, then waits a bounded time for the result
  task automatic run_cmd(input uvepc_cmd_t op, input logic [14:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmdOp <= op;
    cmdAddr <= addr;
    cmdData <= data;
    cmdValid <= 1'b1;
    do @(negedge clk_sys); while (cmdReady !== 1'b1);
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rspValid !== 1'b1 && n < 2000);
    check({7'h0, rspValid}, 8'h01);
  endtask : run_cmd

  task automatic t_idle_pins();
    check({3'h0, chipSel_n, outGate_n, progSupplyHigh, memDataOe, cmdReady}, 8'h19);
  endtask : t_idle_pins

  task automatic t_read_erased();
    logic [14:0] addrs [2];
    addrs = '{15'h0000, 15'h7fff};
    foreach (addrs[i]) begin
      run_cmd(UVEPC_CMD_READ, addrs[i], 8'h00);
      check(rspData, ERASED_BYTE);
      check({7'h0, rspErased}, 8'h01);
      check({7'h0, chipSel_n}, 8'h01);
    end
  endtask : t_read_erased

  task automatic t_program(input logic [14:0] addr, input logic [7:0] data,
                           input logic [7:0] stored);
    progByte = data;
    run_cmd(UVEPC_CMD_PROG, addr, data);
    check(rspData, stored);
    check({7'h0, rspMismatch}, {7'h0, stored !== data});
    run_cmd(UVEPC_CMD_READ, addr, 8'h00);
    check(rspData, stored);
    check({7'h0, rspErased}, {7'h0, stored == 8'hff});
  endtask : t_program

  // Reset in the middle of a program: pins fall back to standby and nothing is written
  task automatic t_mid_reset();
    do @(negedge clk_sys); while (cmdReady !== 1'b1);
    @(posedge clk_sys);
    cmdOp    <= UVEPC_CMD_PROG;
    cmdAddr  <= 15'h0002;
    cmdData  <= 8'h00;
    cmdValid <= 1'b1;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b1;
    @(negedge clk_sys);
    t_idle_pins();
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_idle_pins();
    run_cmd(UVEPC_CMD_READ, 15'h0002, 8'h00);
    check(rspData, ERASED_BYTE);
  endtask : t_mid_reset

  task automatic t_signature();
    run_cmd(UVEPC_CMD_SIG, 15'h7fff, 8'h00);
    check(rspData, MAKER);
    check(rspType, TYPE);
  endtask : t_signature

  // Pin watch: byte driven during the pulse, clean signature address, no contention
  always @(negedge clk_sys) begin
    if (!rst && progSupplyHigh && !chipSel_n) check(memDataOut & {8{memDataOe}}, progByte);
    if (!rst && idHighVoltageLine) check({7'h0, |(memAddr & 15'h7dfe) | progSupplyHigh}, 8'h00);
    if (!rst && memDataOe && devDrive) check(8'h01, 8'h00);
  end

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = UVEPC_CMD_READ;
    cmdAddr = 15'h0000;
    cmdData = 8'h00;
    progByte = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_idle_pins();
    t_read_erased();
    t_program(15'h1234, 8'ha5, 8'ha5);
    t_program(15'h1234, 8'h5a, 8'h00);
    t_program(15'h0001, 8'hff, 8'hff);
    t_read_erased();
    t_signature();
    t_read_erased();
    t_mid_reset();
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    t_idle_pins();
    tally_and_finish();
  end
endmodule : tb_uv_eprom_mode_control
